/* swd_cfg.svh */
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH

// ----------------------------------------
// clock and time conversion
// ----------------------------------------
`define SWD_CLK_HZ 10000000
`define SWD_US_TO_CYC(t) ((t) * (`SWD_CLK_HZ / 1000000))
`define SWD_MS_TO_CYC(t) ((t) * (`SWD_CLK_HZ / 1000))

// ----------------------------------------
// delays
// ----------------------------------------
`define SWD_STARTUP_US 500
`define SWD_RELEASE_FIXED_MS 2
`define SWD_RELEASE_OPEN_MS 2
`define SWD_KICK_OPT0_MS 1
`define SWD_KICK_OPT1_MS 10
`define SWD_KICK_OPT2_MS 1000
`define SWD_KICK_OPT3_MS 100000

// ----------------------------------------
// capacitor sensing
// ----------------------------------------
`define SWD_CAP_MULT_TIMEOUT 32'h0000_0010
`define SWD_CAP_MULT_DELAY 32'h0000_0010
`define SWD_CAP_OPEN_MAX 32'h0000_0004
`define SWD_CNT_MAX 32'hFFFF_FFFF
`define SWD_SET_DISABLE 2'h1

// ----------------------------------------
// register map
// ----------------------------------------
`define SWD_ADDR_W 12
`define SWD_ADDR_CTRL 12'h000
`define SWD_ADDR_STATUS 12'h004
`define SWD_ADDR_INT_STATUS 12'h008
`define SWD_ADDR_INT_MASK 12'h00C
`define SWD_ADDR_KICK_WINDOW 12'h010
`define SWD_ADDR_RELEASE 12'h014
`define SWD_CTRL_RESET 6'h01
`define SWD_INT_RESET 3'h0
`define SWD_SYNC_W 7

`endif

/* swd_pkg.sv */
`include "swd_cfg.svh"

package swd_pkg;

  typedef struct packed {
    logic [1:0] kick_opt;
    logic cap_release;
    logic cap_timeout;
    logic use_set_code;
    logic single_output;
  } swd_ctrl_t;

  typedef struct packed {
    logic release_done;
    logic supply_fail;
    logic timeout;
  } swd_irq_t;

  typedef struct packed {
    logic delay_cap_above;
    logic timeout_cap_above;
    logic supply_low;
    logic [1:0] set_code;
    logic enable;
    logic kick;
  } swd_pins_t;

  typedef struct packed {
    logic charge;
    logic discharge;
  } swd_cap_drive_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`SWD_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } swd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } swd_apb_rsp_t;

  typedef enum logic [2:0] {SUP_POWERUP, SUP_STARTUP, SUP_LOW, SUP_RELEASE, SUP_RUN} swd_sup_t;
  typedef enum logic [1:0] {WD_OFF, WD_WINDOW, WD_FAULT} swd_wd_t;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_CHARGE, MEAS_DISCHARGE, MEAS_DONE} swd_meas_t;

endpackage

/* swd_sync.sv */
`include "swd_cfg.svh"

module swd_sync (
  input logic clk_sys,
  input logic rst,
  input swd_pkg::swd_pins_t pins_raw,
  output swd_pkg::swd_pins_t pins_sync
);
  import swd_pkg::*;

  typedef struct packed {
    logic [`SWD_SYNC_W-1:0] stage1;
    logic [`SWD_SYNC_W-1:0] stage2;
  } swd_sync_state_t;

  swd_sync_state_t state_reg;
  swd_sync_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = pins_raw;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign pins_sync = state_reg.stage2;

endmodule

/* swd_cap_meas.sv */
`include "swd_cfg.svh"

module swd_cap_meas (
  input logic clk_sys,
  input logic rst,
  input logic start,
  input logic above,
  output swd_pkg::swd_cap_drive_t drive,
  output logic done,
  output logic [31:0] count
);
  import swd_pkg::*;

  typedef struct packed {
    swd_meas_t st;
    logic [31:0] cnt;
  } swd_meas_state_t;

  swd_meas_state_t state_reg;
  swd_meas_state_t state_next;

  // ----------------------------------------
  // one charge and one discharge per start
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    if (start)
    begin
      state_next.st = MEAS_CHARGE;
      state_next.cnt = '0;
    end
    else
    begin
      unique case (state_reg.st)
        MEAS_IDLE, MEAS_DONE:
        begin
          state_next.st = state_reg.st;
        end
        MEAS_CHARGE:
        begin
          if (state_reg.cnt != `SWD_CNT_MAX)
            state_next.cnt = state_reg.cnt + 32'h0000_0001;
          if (above)
            state_next.st = MEAS_DISCHARGE;
        end
        MEAS_DISCHARGE:
        begin
          if (!above)
            state_next.st = MEAS_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_reg <= '{st: MEAS_IDLE, cnt: '0};
    else
      state_reg <= state_next;
  end

  assign drive.charge = (state_reg.st == MEAS_CHARGE);
  assign drive.discharge = (state_reg.st == MEAS_DISCHARGE);
  assign done = (state_reg.st == MEAS_DONE);
  assign count = state_reg.cnt;

endmodule

/* swd_top.sv */
// Functional notes
// - from power-up, reset stays asserted for startup delay plus release delay.
// - capacitor release mode with open delay pin uses startup plus fixed 2 ms.
// - single-output variant ANDs active-low supervisor reset and watchdog fault.
// - supply low asserts reset; release delay runs after supply recovers.
// - supervisor reset suspends all watchdog activity including fault output.
// - watchdog runs only after release, while supply good and enabled.
// - host kicks with falling edges; each valid kick restarts the window.
// - missed kick asserts reset or fault output for the release delay.
// - timing capacitors measured once per power-up or supply-low event.
// - capacitor kick window scales linearly with sensed charge time.
// - fixed kick window chosen from options spanning 1 ms to 100 s.
// - disable via enable pin or select code 01, one method per variant.
// - enable pin high enables, low disables, followed at any time.
// - disabling aborts the window and clears fault; enabling starts one at once.
`include "swd_cfg.svh"

module swd_top #(
  parameter logic [31:0] STARTUP_CYC = `SWD_US_TO_CYC(`SWD_STARTUP_US),
  parameter logic [31:0] RELEASE_CYC = `SWD_MS_TO_CYC(`SWD_RELEASE_FIXED_MS),
  parameter logic [31:0] RELEASE_OPEN_CYC = `SWD_MS_TO_CYC(`SWD_RELEASE_OPEN_MS),
  parameter logic [31:0] KICK_OPT0_CYC = `SWD_MS_TO_CYC(`SWD_KICK_OPT0_MS),
  parameter logic [31:0] KICK_OPT1_CYC = `SWD_MS_TO_CYC(`SWD_KICK_OPT1_MS),
  parameter logic [31:0] KICK_OPT2_CYC = `SWD_MS_TO_CYC(`SWD_KICK_OPT2_MS),
  parameter logic [31:0] KICK_OPT3_CYC = `SWD_MS_TO_CYC(`SWD_KICK_OPT3_MS)
) (
  input logic clk_sys,
  input logic rst,
  input swd_pkg::swd_apb_req_t apb_req,
  output swd_pkg::swd_apb_rsp_t apb_rsp,
  input swd_pkg::swd_pins_t pins_in,
  output swd_pkg::swd_cap_drive_t timeout_cap_pin,
  output swd_pkg::swd_cap_drive_t delay_cap_pin,
  output logic reset_out_n,
  output logic watchdog_fault_out_n,
  output logic irq_out
);
  import swd_pkg::*;

  typedef struct packed {
    swd_sup_t sup;
    swd_wd_t wd;
    logic [31:0] sup_cnt;
    logic [31:0] wd_cnt;
    logic kick_prev;
    logic meas_start;
    swd_ctrl_t ctrl;
    swd_irq_t irq_stat;
    swd_irq_t irq_mask;
    logic [31:0] prdata;
    logic pslverr;
    logic reset_n;
    logic fault_n;
    logic irq;
  } swd_state_t;

  swd_state_t state_reg;
  swd_state_t state_next;
  swd_pins_t pins_s;
  logic tmo_done;
  logic dly_done;
  logic [31:0] tmo_count;
  logic [31:0] dly_count;
  logic [31:0] kick_cyc;
  logic [31:0] release_cyc;
  logic delay_open;
  logic meas_ok;
  logic watchdog_enable_in;
  logic kick_fall;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic [31:0] rd_word;
  swd_irq_t events;
  swd_irq_t w1c;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic expired(input logic [31:0] cnt, input logic [31:0] lim);
    logic [32:0] sum;
    sum = {1'b0, cnt} + 33'h0_0000_0001;
    return (sum >= {1'b0, lim});
  endfunction

  function automatic logic [31:0] scale(input logic [31:0] cnt, input logic [31:0] mult);
    logic [63:0] prod;
    prod = cnt * mult;
    if (prod[63:32] != 32'h0000_0000)
      return `SWD_CNT_MAX;
    return prod[31:0];
  endfunction

  function automatic logic [31:0] inc(input logic [31:0] cnt);
    return cnt + 32'h0000_0001;
  endfunction

  // ----------------------------------------
  // input synchroniser and capacitor sensing
  // ----------------------------------------
  swd_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pins_raw(pins_in),
    .pins_sync(pins_s)
  );

  swd_cap_meas u_tmo_meas (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(state_reg.meas_start),
    .above(pins_s.timeout_cap_above),
    .drive(timeout_cap_pin),
    .done(tmo_done),
    .count(tmo_count)
  );

  swd_cap_meas u_dly_meas (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(state_reg.meas_start),
    .above(pins_s.delay_cap_above),
    .drive(delay_cap_pin),
    .done(dly_done),
    .count(dly_count)
  );

  // ----------------------------------------
  // delay limits
  // ----------------------------------------
  always_comb
  begin
    delay_open = (dly_count < `SWD_CAP_OPEN_MAX);
    if (state_reg.ctrl.cap_timeout)
      kick_cyc = scale(tmo_count, `SWD_CAP_MULT_TIMEOUT);
    else
    begin
      unique case (state_reg.ctrl.kick_opt)
        2'h0: kick_cyc = KICK_OPT0_CYC;
        2'h1: kick_cyc = KICK_OPT1_CYC;
        2'h2: kick_cyc = KICK_OPT2_CYC;
        2'h3: kick_cyc = KICK_OPT3_CYC;
      endcase
    end
    if (!state_reg.ctrl.cap_release)
      release_cyc = RELEASE_CYC;
    else if (delay_open)
      release_cyc = RELEASE_OPEN_CYC;
    else
      release_cyc = scale(dly_count, `SWD_CAP_MULT_DELAY);
    meas_ok = (!state_reg.ctrl.cap_timeout || tmo_done) && (!state_reg.ctrl.cap_release || dly_done);
  end

  // ----------------------------------------
  // enable and kick detection
  // ----------------------------------------
  always_comb
  begin
    if (state_reg.ctrl.use_set_code)
      watchdog_enable_in = (pins_s.set_code != `SWD_SET_DISABLE);
    else
      watchdog_enable_in = pins_s.enable;
    kick_fall = state_reg.kick_prev && !pins_s.kick;
  end

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  always_comb
  begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (apb_req.paddr)
      `SWD_ADDR_CTRL: rd_word = {26'h000_0000, state_reg.ctrl};
      `SWD_ADDR_STATUS: rd_word = {24'h00_0000, dly_done, tmo_done, watchdog_enable_in, state_reg.wd, state_reg.sup};
      `SWD_ADDR_INT_STATUS: rd_word = {29'h0000_0000, state_reg.irq_stat};
      `SWD_ADDR_INT_MASK: rd_word = {29'h0000_0000, state_reg.irq_mask};
      `SWD_ADDR_KICK_WINDOW: rd_word = kick_cyc;
      `SWD_ADDR_RELEASE: rd_word = release_cyc;
      default: addr_ok = 1'b0;
    endcase
    apb_setup = apb_req.psel && !apb_req.penable;
    apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.meas_start = 1'b0;
    state_next.kick_prev = pins_s.kick;
    events = '0;
    w1c = '0;

    // supervisor sequence
    unique case (state_reg.sup)
      SUP_POWERUP:
      begin
        state_next.sup_cnt = '0;
        if (!pins_s.supply_low)
          state_next.sup = SUP_STARTUP;
      end
      SUP_STARTUP:
      begin
        if (pins_s.supply_low)
        begin
          state_next.sup = SUP_LOW;
          state_next.sup_cnt = '0;
          state_next.meas_start = 1'b1;
          events.supply_fail = 1'b1;
        end
        else if (expired(state_reg.sup_cnt, STARTUP_CYC))
        begin
          state_next.sup = SUP_RELEASE;
          state_next.sup_cnt = '0;
        end
        else
          state_next.sup_cnt = inc(state_reg.sup_cnt);
      end
      SUP_LOW:
      begin
        state_next.sup_cnt = '0;
        if (!pins_s.supply_low)
          state_next.sup = SUP_RELEASE;
      end
      SUP_RELEASE:
      begin
        if (pins_s.supply_low)
        begin
          state_next.sup = SUP_LOW;
          state_next.sup_cnt = '0;
          state_next.meas_start = 1'b1;
          events.supply_fail = 1'b1;
        end
        else if (!meas_ok)
          state_next.sup_cnt = '0;
        else if (expired(state_reg.sup_cnt, release_cyc))
        begin
          state_next.sup = SUP_RUN;
          state_next.sup_cnt = '0;
          events.release_done = 1'b1;
        end
        else
          state_next.sup_cnt = inc(state_reg.sup_cnt);
      end
      SUP_RUN:
      begin
        if (pins_s.supply_low)
        begin
          state_next.sup = SUP_LOW;
          state_next.meas_start = 1'b1;
          events.supply_fail = 1'b1;
        end
      end
      default:
      begin
        state_next.sup = SUP_POWERUP;
        state_next.sup_cnt = '0;
      end
    endcase

    // watchdog sequence, suspended unless released and enabled
    unique case (state_reg.wd)
      WD_OFF:
      begin
        state_next.wd_cnt = '0;
        if (state_reg.sup == SUP_RUN && watchdog_enable_in)
          state_next.wd = WD_WINDOW;
      end
      WD_WINDOW:
      begin
        if (state_reg.sup != SUP_RUN || !watchdog_enable_in)
        begin
          state_next.wd = WD_OFF;
          state_next.wd_cnt = '0;
        end
        else if (kick_fall)
          state_next.wd_cnt = '0;
        else if (expired(state_reg.wd_cnt, kick_cyc))
        begin
          state_next.wd = WD_FAULT;
          state_next.wd_cnt = '0;
          events.timeout = 1'b1;
        end
        else
          state_next.wd_cnt = inc(state_reg.wd_cnt);
      end
      WD_FAULT:
      begin
        if (state_reg.sup != SUP_RUN || !watchdog_enable_in)
        begin
          state_next.wd = WD_OFF;
          state_next.wd_cnt = '0;
        end
        else if (expired(state_reg.wd_cnt, release_cyc))
        begin
          state_next.wd = WD_WINDOW;
          state_next.wd_cnt = '0;
        end
        else
          state_next.wd_cnt = inc(state_reg.wd_cnt);
      end
      default:
      begin
        state_next.wd = WD_OFF;
        state_next.wd_cnt = '0;
      end
    endcase

    // bus slave, zero wait states
    if (apb_setup)
    begin
      state_next.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_word;
      state_next.pslverr = !addr_ok;
    end
    if (apb_write)
    begin
      unique case (apb_req.paddr)
        `SWD_ADDR_CTRL: state_next.ctrl = apb_req.pwdata[5:0];
        `SWD_ADDR_INT_STATUS: w1c = apb_req.pwdata[2:0];
        `SWD_ADDR_INT_MASK: state_next.irq_mask = apb_req.pwdata[2:0];
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end

    // new events win over a clear in the same cycle
    state_next.irq_stat = (state_reg.irq_stat & ~w1c) | events;
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // output pins from flops
    state_next.fault_n = (state_next.wd != WD_FAULT);
    if (state_next.ctrl.single_output)
    begin
      state_next.reset_n = (state_next.sup == SUP_RUN) && state_next.fault_n;
      state_next.fault_n = 1'b1;
    end
    else
      state_next.reset_n = (state_next.sup == SUP_RUN);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.sup <= SUP_POWERUP;
      state_reg.wd <= WD_OFF;
      state_reg.meas_start <= 1'b1;
      state_reg.ctrl <= `SWD_CTRL_RESET;
      state_reg.irq_stat <= `SWD_INT_RESET;
      state_reg.irq_mask <= `SWD_INT_RESET;
      state_reg.fault_n <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apb_rsp.prdata = state_reg.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = state_reg.pslverr && apb_req.psel && apb_req.penable;
  assign reset_out_n = state_reg.reset_n;
  assign watchdog_fault_out_n = state_reg.fault_n;
  assign irq_out = state_reg.irq;

endmodule

/* swd_top_checker.sv */
module swd_top_checker (
  input logic clk_sys,
  input logic rst,
  input swd_pkg::swd_apb_req_t apb_req,
  input swd_pkg::swd_apb_rsp_t apb_rsp,
  input swd_pkg::swd_pins_t pins_in,
  input swd_pkg::swd_cap_drive_t timeout_cap_pin,
  input swd_pkg::swd_cap_drive_t delay_cap_pin,
  input logic reset_out_n,
  input logic watchdog_fault_out_n,
  input logic irq_out
);
  import swd_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  AST_PREADY: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("pready low in access phase");
  AST_PSLVERR_GATED: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("pslverr outside access phase");

  // ----------------------------------------
  // supervisor
  // ----------------------------------------
  AST_POWERUP_HOLD: assert property ($fell(rst) |-> !reset_out_n [*8])
    else $error("reset released too early after power-up");
  AST_SUPPLY_ASSERT: assert property (pins_in.supply_low [*6] |-> !reset_out_n)
    else $error("reset not asserted on supply low");
  AST_RELEASE_HOLD: assert property ($fell(pins_in.supply_low) && !reset_out_n |-> !reset_out_n [*8])
    else $error("reset released without release delay");
  AST_SUSPEND_FAULT: assert property (pins_in.supply_low [*6] |-> watchdog_fault_out_n)
    else $error("fault output driven during supervisor reset");
  AST_NO_RECHARGE: assert property (reset_out_n |-> !timeout_cap_pin.charge && !delay_cap_pin.charge)
    else $error("capacitor cycled during normal operation");

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  AST_FAULT_HOLD: assert property ($fell(watchdog_fault_out_n) |->
    (!watchdog_fault_out_n || !pins_in.enable || pins_in.supply_low) [*8])
    else $error("fault output released too early");
  AST_DISABLE_QUIET: assert property (!pins_in.enable [*6] |-> watchdog_fault_out_n)
    else $error("fault output asserted while disabled");

  COV_FAULT: cover property ($fell(watchdog_fault_out_n));
  COV_RELEASE: cover property ($rose(reset_out_n));
  COV_SLVERR: cover property (apb_rsp.pslverr);
  COV_IRQ: cover property ($rose(irq_out));
endmodule

/* swd_host.sv */
module swd_host (
  input wire logic clk_sys,
  input wire logic active,
  output logic kick
);
  int cnt = 0;

  initial kick = 1'b1;

  // falling edge every ten cycles, five high and five low; idles high when stopped
  always_ff @(posedge clk_sys)
  begin
    if (!active)
    begin
      cnt <= 0;
      kick <= 1'b1;
    end
    else
    begin
      cnt <= (cnt == 4) ? 0 : cnt + 1;
      if (cnt == 4)
        kick <= ~kick;
    end
  end
endmodule

/* swd_top_tb.sv */
`include "swd_cfg.svh"

module swd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swd_pkg::*;

  localparam int CAPN = 5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  swd_apb_req_t req = '0;
  swd_apb_rsp_t rsp;
  swd_pins_t pins;
  swd_cap_drive_t tcap, dcap;
  logic rn, fn, irq, kick, err;
  logic host_on = 1'b1;
  logic en = 1'b1;
  logic sup = 1'b0;
  logic [1:0] setc = 2'h0;
  int cap_cnt = 0;
  int chg_rises = 0;
  int bad_count = 0;
  int cmp_count = 0;

  always #50 clk_sys = ~clk_sys;

  // timing capacitor: rises while charged, comparator trips at CAPN; delay pin left open
  always_ff @(posedge clk_sys)
    cap_cnt <= tcap.discharge ? 0 : (tcap.charge ? cap_cnt + 1 : cap_cnt);
  always @(posedge tcap.charge) chg_rises++;
  // open delay pin: its comparator follows the charge drive at once
  assign pins = {dcap.charge, (cap_cnt >= CAPN), sup, setc, en, kick};

  swd_host host (.clk_sys(clk_sys), .active(host_on), .kick(kick));

  swd_top #(.STARTUP_CYC(20), .RELEASE_CYC(30), .RELEASE_OPEN_CYC(25), .KICK_OPT0_CYC(40),
    .KICK_OPT1_CYC(60)) dut (
    .clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp), .pins_in(pins),
    .timeout_cap_pin(tcap), .delay_cap_pin(dcap), .reset_out_n(rn),
    .watchdog_fault_out_n(fn), .irq_out(irq));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, n, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  // cycles until reset (f=0) or fault (f=1) output reaches lvl, capped at lim
  task automatic until_lvl(input bit f, input logic lvl, input int lim, output int n);
    n = 0;
    while (((f ? fn : rn) !== lvl) && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_regs();
    int n;
    logic [31:0] q;
    logic [31:0] kw [4];
    kw = '{32'h0000_0028, 32'h0000_003C, `SWD_MS_TO_CYC(`SWD_KICK_OPT2_MS), `SWD_MS_TO_CYC(`SWD_KICK_OPT3_MS)};
    until_lvl(0, 1'b1, 200, n);
    chk_rng(n, 50, 60);
    rd(`SWD_ADDR_CTRL, 32'h0000_0001);
    rd(`SWD_ADDR_INT_MASK, 32'h0000_0000);
    rd(`SWD_ADDR_RELEASE, 32'h0000_001E);
    wr(`SWD_ADDR_KICK_WINDOW, 32'hFFFF_FFFF);
    for (int k = 0; k < 4; k++)
    begin
      wr(`SWD_ADDR_CTRL, {26'h0, k[1:0], 4'h1});
      rd(`SWD_ADDR_KICK_WINDOW, kw[k]);
    end
    wr(`SWD_ADDR_CTRL, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h1);
    until_lvl(0, 1'b0, 300, n);
    chk_rng(n, 300, 300);
  endtask

  task automatic t_timeout();
    int n;
    logic [31:0] q;
    wr(`SWD_ADDR_INT_MASK, 32'h0000_0007);
    wr(`SWD_ADDR_INT_STATUS, 32'h0000_0007);
    host_on <= 1'b0;
    until_lvl(0, 1'b0, 100, n);
    chk_rng(n, 28, 50);
    chk({31'h0, fn}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    until_lvl(0, 1'b1, 100, n);
    chk_rng(n, 28, 33);
    host_on <= 1'b1;
    apb(1'b0, `SWD_ADDR_INT_STATUS, 32'h0, q);
    chk({31'h0, q[0]}, 32'h1);
    wr(`SWD_ADDR_INT_STATUS, 32'h0000_0007);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_enable();
    int n;
    wr(`SWD_ADDR_CTRL, 32'h0000_0000);
    host_on <= 1'b0;
    until_lvl(1, 1'b0, 100, n);
    chk({31'h0, rn}, 32'h1);
    @(posedge clk_sys);
    en <= 1'b0;
    until_lvl(1, 1'b1, 8, n);
    chk_rng(n, 0, 7);
    until_lvl(1, 1'b0, 200, n);
    chk_rng(n, 200, 200);
    @(posedge clk_sys);
    en <= 1'b1;
    until_lvl(1, 1'b0, 100, n);
    chk_rng(n, 38, 46);
    host_on <= 1'b1;
    until_lvl(1, 1'b1, 100, n);
    wr(`SWD_ADDR_CTRL, 32'h0000_0002);
    setc <= 2'h1;
    host_on <= 1'b0;
    until_lvl(1, 1'b0, 200, n);
    chk_rng(n, 200, 200);
    @(posedge clk_sys);
    setc <= 2'h0;
    until_lvl(1, 1'b0, 100, n);
    chk_rng(n, 38, 46);
    host_on <= 1'b1;
    until_lvl(1, 1'b1, 100, n);
    wr(`SWD_ADDR_CTRL, 32'h0000_0000);
  endtask

  task automatic t_supply_cap();
    int n, r;
    logic [31:0] q;
    host_on <= 1'b0;
    until_lvl(1, 1'b0, 100, n);
    chk_rng(n, 28, 50);
    @(posedge clk_sys);
    sup <= 1'b1;
    until_lvl(0, 1'b0, 8, n);
    chk_rng(n, 1, 6);
    repeat (9) @(posedge clk_sys);
    #1;
    chk({31'h0, fn}, 32'h1);
    @(posedge clk_sys);
    sup <= 1'b0;
    host_on <= 1'b1;
    until_lvl(0, 1'b1, 100, n);
    chk_rng(n, 30, 38);
    wr(`SWD_ADDR_CTRL, 32'h0000_000D);
    sup <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sup <= 1'b0;
    until_lvl(0, 1'b1, 400, n);
    chk_rng(n, 25, 60);
    r = chg_rises;
    rd(`SWD_ADDR_RELEASE, 32'h0000_0019);
    apb(1'b0, `SWD_ADDR_KICK_WINDOW, 32'h0, q);
    chk_rng(q, 16 * (CAPN - 1), 16 * (CAPN + 4));
    repeat (300) @(posedge clk_sys);
    chk(chg_rises, r);
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #(100 * 20000);
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_regs();
    t_timeout();
    t_enable();
    t_supply_cap();
    summarize();
  end
endmodule

bind swd_top swd_top_checker chk_i (
  .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins_in(pins_in),
  .timeout_cap_pin(timeout_cap_pin), .delay_cap_pin(delay_cap_pin), .reset_out_n(reset_out_n),
  .watchdog_fault_out_n(watchdog_fault_out_n), .irq_out(irq_out));
